/* File: src/xp_host.sv */
/*
 * Host controller for the parallel configuration port of a 33x17
 * crosspoint switch. Software issues one command at a time through a
 * plain register port; the sequencer then drives the strobes in vector
 * steps of at least 15 ns and reads back second-rank words.
 * Assumes: one 125 MHz clock, switch pins reached directly, the switch
 * drives the data pins only while the readback strobe is low.
 */
`timescale 1ns/1ps
`include "xp_cfg.svh"
`default_nettype none

module xp_host (
    input wire logic I_REF_CLK,
    input wire logic I_NRST,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    output logic O_XP_OFF_N,
    output logic O_XP_SEL_N,
    output logic O_XP_WRITE_N,
    output logic O_XP_UPDATE_N,
    output logic O_RANK_TWO_OUTPUT_DRIVE_N,
    output logic [`XP_ADDR_W-1:0] O_XP_ADDR,
    output logic [`XP_DATA_W-1:0] O_XP_DATA,
    output logic O_XP_DATA_OE_N,
    input wire logic [`XP_DATA_W-1:0] I_XP_DATA
);
    logic rst_meta;                    // Reset release, first stage
    logic rst_n;                       // Reset used by all logic
    xp_pkg::step_t state;              // Sequencer step
    xp_pkg::step_t next_state;         // Step for the next cycle
    xp_pkg::op_t cur_op;               // Command being carried out
    xp_pkg::op_t req_op;               // Command field of a write
    logic cur_fast;                    // Fast mode latched at start
    logic [`XP_ADDR_W-1:0] row_addr;   // Software row address
    logic [`XP_DATA_W-1:0] row_data;   // Software row word
    logic [`XP_ADDR_W-1:0] cur_addr;   // Address latched at start
    logic [`XP_DATA_W-1:0] cur_data;   // Word latched at start
    logic [`XP_DATA_W-1:0] rb_data;    // Last word read back
    logic [`XP_DATA_W-1:0] pins_sync;  // Synchronised data pins
    logic fast;                        // Mode: drop idle vectors
    logic done;                        // Sticky: command finished
    logic refused;                     // Sticky: command refused
    logic busy;                        // Sequencer not idle
    logic cmd_wr;                      // Write to the command register
    logic cmd_legal;                   // Command may start now
    logic cmd_go;                      // Command accepted
    logic applies;                     // Command changes the outputs
    logic rb_take;                     // Capture readback word

    xp_step_if step ();

    // Reset released through two flops, asserted at once
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    xp_step_timer u_timer (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .step(step.timer)
    );

    // Data pins are asynchronous to us: sample through two flops
    xp_pin_sampler u_sampler (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_pins(I_XP_DATA),
        .o_pins(pins_sync)
    );

    assign busy = (state != xp_pkg::ST_IDLE);
    assign cmd_wr = I_WR && (I_ADDR == `XP_REG_CMD);
    assign req_op = xp_pkg::op_t'(I_WDATA[2:0]);
    assign applies = (cur_op != xp_pkg::OP_WRITE) &&
        (cur_op != xp_pkg::OP_READ);
    assign rb_take = (state == xp_pkg::ST_STROBE) &&
        (cur_op == xp_pkg::OP_READ) && step.expired;

    // Reject reserved rows, reserved inputs and broadcast readback
    always_comb begin
        cmd_legal = !busy;
        unique case (req_op)
            xp_pkg::OP_OFF, xp_pkg::OP_UPDATE: begin
            end
            xp_pkg::OP_WRITE, xp_pkg::OP_TWRITE: begin
                // Broadcast row is legal for writes
                if (row_addr > `XP_BCAST_ADDR) cmd_legal = 1'b0;
                if (row_data[`XP_SEL_W-1:0] > `XP_MAX_INPUT) begin
                    cmd_legal = 1'b0;
                end
            end
            xp_pkg::OP_READ: begin
                // Broadcast row cannot be read back
                if (row_addr >= `XP_BCAST_ADDR) cmd_legal = 1'b0;
            end
            default: cmd_legal = 1'b0; // Codes 0, 6, 7
        endcase
    end
    assign cmd_go = cmd_wr && cmd_legal;

    // Software settings
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            row_addr <= `XP_ADDR_RST;
            row_data <= `XP_DATA_RST;
            fast <= 1'b0;
        end else if (I_WR) begin
            if (I_ADDR == `XP_REG_ROW_ADDR) begin
                row_addr <= I_WDATA[`XP_ADDR_W-1:0];
            end
            if (I_ADDR == `XP_REG_ROW_DATA) begin
                row_data <= I_WDATA[`XP_DATA_W-1:0];
            end
            if (I_ADDR == `XP_REG_MODE) begin
                fast <= I_WDATA[`XP_MODE_FAST];
            end
        end
    end

    // Command latched at acceptance so later writes cannot disturb it
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cur_op <= xp_pkg::OP_NONE;
            cur_fast <= 1'b0;
            cur_addr <= `XP_ADDR_RST;
            cur_data <= `XP_DATA_RST;
        end else if (cmd_go) begin
            cur_op <= req_op;
            cur_fast <= fast;
            cur_addr <= row_addr;
            cur_data <= row_data;
        end
    end

    // Step order: setup (skipped by disable), strobe, optional gap, optional settle, release
    always_comb begin
        next_state = state;
        unique case (state)
            xp_pkg::ST_IDLE: begin
                if (cmd_go) begin
                    // Disable pulse needs no select
                    next_state = (req_op == xp_pkg::OP_OFF) ?
                        xp_pkg::ST_STROBE : xp_pkg::ST_SETUP;
                end
            end
            xp_pkg::ST_SETUP: begin
                if (step.expired) next_state = xp_pkg::ST_STROBE;
            end
            xp_pkg::ST_STROBE: begin
                if (step.expired) begin
                    if (!cur_fast) begin
                        next_state = xp_pkg::ST_GAP;
                    end else if (applies) begin
                        next_state = xp_pkg::ST_SETTLE;
                    end else begin
                        next_state = xp_pkg::ST_RELEASE;
                    end
                end
            end
            xp_pkg::ST_GAP: begin
                if (step.expired) begin
                    next_state = applies ? xp_pkg::ST_SETTLE :
                        xp_pkg::ST_RELEASE;
                end
            end
            xp_pkg::ST_SETTLE: begin
                if (step.expired) next_state = xp_pkg::ST_RELEASE;
            end
            xp_pkg::ST_RELEASE: next_state = xp_pkg::ST_IDLE;
        endcase
    end

    // Step length of the step being entered
    always_comb begin
        step.load = (next_state != state);
        unique case (next_state)
            xp_pkg::ST_STROBE: begin
                // From idle the latched op is still the previous one
                step.cycles = (((state == xp_pkg::ST_IDLE) ? req_op :
                    cur_op) == xp_pkg::OP_READ) ?
                    4'(`XP_RB_CYC) : 4'(`XP_VEC_CYC);
            end
            // Outputs settle within 30 ns before we report done
            xp_pkg::ST_SETTLE: step.cycles = 4'(`XP_APPLY_CYC);
            xp_pkg::ST_SETUP, xp_pkg::ST_GAP: step.cycles = 4'(`XP_VEC_CYC);
            default: step.cycles = 4'h1;
        endcase
    end

    // Sequencer register
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= xp_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Pin drivers: registered, lag the step by one cycle
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_XP_OFF_N <= 1'b1;
            O_XP_SEL_N <= 1'b1;
            O_XP_WRITE_N <= 1'b1;
            O_XP_UPDATE_N <= 1'b1;
            O_RANK_TWO_OUTPUT_DRIVE_N <= 1'b1;
            O_XP_DATA_OE_N <= 1'b1;
        end else begin
            // Disable pulse ignores select entirely
            O_XP_OFF_N <= !(state == xp_pkg::ST_STROBE &&
                cur_op == xp_pkg::OP_OFF);
            O_XP_SEL_N <= !(busy && state != xp_pkg::ST_RELEASE &&
                cur_op != xp_pkg::OP_OFF);
            O_XP_WRITE_N <= !(state == xp_pkg::ST_STROBE &&
                (cur_op == xp_pkg::OP_WRITE ||
                 cur_op == xp_pkg::OP_TWRITE));
            // Update held low alongside write gives pass-through
            O_XP_UPDATE_N <= !(state == xp_pkg::ST_STROBE &&
                (cur_op == xp_pkg::OP_UPDATE ||
                 cur_op == xp_pkg::OP_TWRITE));
            O_RANK_TWO_OUTPUT_DRIVE_N <= !(state == xp_pkg::ST_STROBE &&
                cur_op == xp_pkg::OP_READ);
            // Never drive while the switch may drive readback
            O_XP_DATA_OE_N <= !((cur_op == xp_pkg::OP_WRITE ||
                cur_op == xp_pkg::OP_TWRITE) &&
                (state == xp_pkg::ST_SETUP || state == xp_pkg::ST_STROBE ||
                 state == xp_pkg::ST_GAP));
        end
    end

    // Address and word pins follow the latched command
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_XP_ADDR <= `XP_ADDR_RST;
            O_XP_DATA <= `XP_DATA_RST;
        end else begin
            O_XP_ADDR <= cur_addr;
            O_XP_DATA <= cur_data;
        end
    end

    // Readback word captured at the strobe's last cycle
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rb_data <= `XP_DATA_RST;
        end else if (rb_take) begin
            rb_data <= pins_sync;
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
            refused <= 1'b0;
        end else begin
            done <= (state == xp_pkg::ST_RELEASE) || (done &&
                !(I_WR && I_ADDR == `XP_REG_STATUS &&
                  I_WDATA[`XP_ST_DONE]));
            refused <= (cmd_wr && !cmd_legal) || (refused &&
                !(I_WR && I_ADDR == `XP_REG_STATUS &&
                  I_WDATA[`XP_ST_REFUSED]));
        end
    end

    // Read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_RDATA <= 32'h00000000;
        end else if (I_RD) begin
            unique case (I_ADDR)
                `XP_REG_CMD: O_RDATA <= {29'h0, cur_op};
                `XP_REG_ROW_ADDR: O_RDATA <= {27'h0, row_addr};
                `XP_REG_ROW_DATA: O_RDATA <= {25'h0, row_data};
                `XP_REG_STATUS: O_RDATA <= {29'h0, refused, done, busy};
                `XP_REG_READBACK: O_RDATA <= {25'h0, rb_data};
                `XP_REG_MODE: O_RDATA <= {31'h0, fast};
                default: O_RDATA <= 32'h00000000;
            endcase
        end else begin
            O_RDATA <= 32'h00000000;
        end
    end

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!rst_n);

    a_off_pulse_width: assert property ($fell(O_XP_OFF_N) |->
        !O_XP_OFF_N [*2]) else $error("disable pulse too short");
    a_update_width: assert property ($fell(O_XP_UPDATE_N) |->
        !O_XP_UPDATE_N [*2]) else $error("update pulse too short");
    a_transp_hold: assert property (!O_XP_WRITE_N &&
        cur_op == xp_pkg::OP_TWRITE |-> !O_XP_UPDATE_N)
        else $error("write not under update");
    a_rb_bus_free: assert property (!O_RANK_TWO_OUTPUT_DRIVE_N |->
        O_XP_DATA_OE_N) else $error("driving data in readback");
    a_rb_strobe_len: assert property ($fell(O_RANK_TWO_OUTPUT_DRIVE_N)
        |-> !O_RANK_TWO_OUTPUT_DRIVE_N [*8])
        else $error("readback strobe too short");
    a_no_bcast_read: assert property (!O_RANK_TWO_OUTPUT_DRIVE_N |->
        O_XP_ADDR < `XP_BCAST_ADDR) else $error("broadcast read");
    a_update_alone: assert property (!O_XP_UPDATE_N &&
        cur_op == xp_pkg::OP_UPDATE |-> O_XP_WRITE_N)
        else $error("write during global update");
    a_conservative_gap: assert property ($rose(O_XP_WRITE_N) &&
        !cur_fast |-> !O_XP_SEL_N [*2])
        else $error("idle vector missing");
    a_fast_no_gap: assert property ($rose(O_XP_WRITE_N) && cur_fast &&
        cur_op == xp_pkg::OP_WRITE |=> O_XP_SEL_N) else $error("gap kept");
    a_strobe_select: assert property ((!O_XP_WRITE_N ||
        !O_XP_UPDATE_N || !O_RANK_TWO_OUTPUT_DRIVE_N) |-> !O_XP_SEL_N)
        else $error("strobe without select");
    a_off_alone: assert property (!O_XP_OFF_N |-> O_XP_SEL_N &&
        O_XP_WRITE_N) else $error("disable touched first rank");
    a_write_setup: assert property ($fell(O_XP_WRITE_N) |->
        $past(!O_XP_SEL_N, 2) && $stable(O_XP_DATA) && !O_XP_DATA_OE_N)
        else $error("write word not set up");

    c_broadcast: cover property (!O_XP_WRITE_N &&
        O_XP_ADDR == `XP_BCAST_ADDR && O_XP_DATA == 7'h47);
    c_top_row: cover property (!O_XP_WRITE_N &&
        O_XP_ADDR == 5'h10 && O_XP_DATA == 7'h60);
    c_readback: cover property (rb_take);
    c_transparent: cover property (!O_XP_WRITE_N && !O_XP_UPDATE_N);
endmodule : xp_host
`default_nettype wire

/* File: src/xp_cfg.svh */
/*
 * Constants of the crosspoint configuration host: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 125 MHz reference clock; include by bare name.
 */
`ifndef XP_CFG_SVH
`define XP_CFG_SVH

// Register byte offsets of the host's own command port
`define XP_REG_CMD 8'h00
`define XP_REG_ROW_ADDR 8'h04
`define XP_REG_ROW_DATA 8'h08
`define XP_REG_STATUS 8'h0C
`define XP_REG_READBACK 8'h10
`define XP_REG_MODE 8'h14

// Status field positions
`define XP_ST_BUSY 0
`define XP_ST_DONE 1
`define XP_ST_REFUSED 2
// Mode field position
`define XP_MODE_FAST 0

// Row word layout on the data pins
`define XP_ADDR_W 5
`define XP_DATA_W 7
`define XP_SEL_W 6
`define XP_ON_BIT 6
`define XP_BCAST_ADDR 5'h11
`define XP_MAX_INPUT 6'h20

// Reset values
`define XP_ADDR_RST 5'h00
`define XP_DATA_RST 7'h00

// Timing: clock period in ps, times in ns as documented
`define XP_CLK_PS 8000
`define XP_VEC_NS 15
`define XP_APPLY_NS 30
`define XP_SYNC_CYC 2
// Least times round up to whole cycles
`define XP_VEC_CYC ((`XP_VEC_NS * 1000 + `XP_CLK_PS - 1) / `XP_CLK_PS)
`define XP_APPLY_CYC ((`XP_APPLY_NS * 1000 + `XP_CLK_PS - 1) / `XP_CLK_PS)
// Readback strobe: access time, input sync, pin register lag and margin
`define XP_RB_CYC (`XP_APPLY_CYC + `XP_SYNC_CYC + 2)

`endif

/* File: src/xp_pkg.sv */
/*
 * Types shared by the crosspoint configuration host.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package xp_pkg;
    // Commands software may issue; numeric value is the CMD field
    typedef enum logic [2:0] {
        OP_NONE, OP_OFF, OP_WRITE, OP_UPDATE, OP_READ, OP_TWRITE
    } op_t;

    // Sequencer steps, one vector or more each except the one-cycle release
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_SETTLE, ST_RELEASE
    } step_t;
endpackage : xp_pkg

/* File: src/xp_step_if.sv */
/*
 * Carrier between the sequencer and its step timer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface xp_step_if;
    logic load;          // Start a new step
    logic [3:0] cycles;  // Step length in cycles, at least one
    logic expired;       // Last cycle of the step

    modport owner (output load, output cycles, input expired);
    modport timer (input load, input cycles, output expired);
endinterface : xp_step_if
`default_nettype wire

/* File: src/xp_step_timer.sv */
/*
 * Step timer: counts the length of one sequencer step.
 * Assumes load comes one cycle before the step begins.
 */
`timescale 1ns/1ps
`default_nettype none
module xp_step_timer (
    input wire logic i_clk,
    input wire logic i_rst_n,
    xp_step_if.timer step
);
    logic [3:0] count; // Cycles left in the current step

    // Reload on a new step, else count down to zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= 4'h0;
        end else if (step.load) begin
            count <= step.cycles;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end
    end

    // Combinational handshake: the step's last cycle
    assign step.expired = (count == 4'h1);
endmodule : xp_step_timer
`default_nettype wire

/* File: src/xp_pin_sampler.sv */
/*
 * Two-flop synchroniser for the data pins read back from the switch.
 * Assumes the pins change without regard to the local clock.
 */
`timescale 1ns/1ps
`include "xp_cfg.svh"
`default_nettype none
module xp_pin_sampler (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [`XP_DATA_W-1:0] i_pins,
    output logic [`XP_DATA_W-1:0] o_pins
);
    logic [`XP_DATA_W-1:0] meta; // First stage, read only by second

    // One pair of flops per data bit
    for (genvar b = 0; b < `XP_DATA_W; b++) begin : g_bit
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                meta[b] <= 1'b0;
                o_pins[b] <= 1'b0;
            end else begin
                meta[b] <= i_pins[b];
                o_pins[b] <= meta[b];
            end
        end
    end
endmodule : xp_pin_sampler
`default_nettype wire

/* File: bench/xp_switch_model.sv */
/*
 * Behavioural model of the switch's configuration port: two ranks of
 * seventeen 7-bit rows and the readback driver on the data pins.
 * Assumes level-sensitive pins driven by the host under test.
 */
`timescale 1ns/1ps
`default_nettype none
module xp_switch_model #(
    parameter int RB_NS = 30  // Readback drive and release lag
) (
    input wire logic i_off_n,
    input wire logic i_sel_n,
    input wire logic i_write_n,
    input wire logic i_update_n,
    input wire logic i_re_n,
    input wire logic [4:0] i_addr,
    input wire logic [6:0] i_data,
    output logic [6:0] o_data,
    output logic o_data_oe_n
);
    logic [6:0] rank1 [0:16]; // Preprogrammed rows, unknown at power-up
    logic [6:0] rank2 [0:16]; // Rows that set the connections
    wire logic drive; // Readback driver on, after its lag

    // Latches follow the pins at once; nothing is edge-triggered
    always @(i_off_n, i_sel_n, i_write_n, i_update_n, i_addr, i_data) begin
        if (!i_sel_n && !i_write_n) begin
            for (int i = 0; i < 17; i++) begin
                if (i_addr == 5'h11 || i_addr == 5'(i)) begin
                    rank1[i] = i_data;
                end
            end
        end
        // Update copies all rows; a write under update passes through
        if (!i_sel_n && !i_update_n) begin
            for (int i = 0; i < 17; i++) begin
                rank2[i] = rank1[i];
            end
        end
        // Off ignores select and spares the first rank
        if (!i_off_n) begin
            for (int i = 0; i < 17; i++) begin
                rank2[i][6] = 1'b0;
            end
        end
    end

    // Slowest legal driver: late on, late off, so stale sampling shows
    assign #(RB_NS) drive = !i_sel_n && !i_re_n;
    assign o_data_oe_n = !drive;
    assign o_data = (i_addr < 5'h11) ? rank2[i_addr] : 7'h00;
endmodule : xp_switch_model
`default_nettype wire

/* File: bench/xp_host_tb.sv */
/*
 * Self-checking bench for the crosspoint configuration host with the
 * switch model on its pins.
 * Assumes the design sources and their include path.
 */
`timescale 1ns/1ps
`include "xp_cfg.svh"
`default_nettype none
`define CHK(nm, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("[ERR] %s expected %h seen %h", nm, e, g); \
    end \
end
module xp_host_tb;
    logic I_REF_CLK = 1'b0; // 125 MHz
    logic I_NRST = 1'b0; // Held low from time zero
    logic [7:0] I_ADDR = 8'h00;
    logic [31:0] I_WDATA = 32'h00000000;
    logic I_WR = 1'b0;
    logic I_RD = 1'b0;
    wire logic [31:0] rdata;
    wire logic off_n, sel_n, wr_n, upd_n, re_n, host_oe_n, dev_oe_n;
    wire logic [4:0] addr;
    wire logic [6:0] host_d, dev_d;
    wire logic [2:0] strb; // Strobes whose width is watched
    logic [6:0] pins; // Resolved data wire
    logic [6:0] last = 7'h2A; // Last driven wire level
    int lowc [3] = '{0, 0, 0}; // Low cycles of each strobe
    int fails = 0;
    int samples_checked = 0;

    always #4 I_REF_CLK = ~I_REF_CLK;

    xp_host dut (.I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST),
        .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
        .O_RDATA(rdata), .O_XP_OFF_N(off_n), .O_XP_SEL_N(sel_n),
        .O_XP_WRITE_N(wr_n), .O_XP_UPDATE_N(upd_n),
        .O_RANK_TWO_OUTPUT_DRIVE_N(re_n), .O_XP_ADDR(addr),
        .O_XP_DATA(host_d), .O_XP_DATA_OE_N(host_oe_n), .I_XP_DATA(pins));

    xp_switch_model #(.RB_NS(30)) sw (.i_off_n(off_n), .i_sel_n(sel_n),
        .i_write_n(wr_n), .i_update_n(upd_n), .i_re_n(re_n),
        .i_addr(addr), .i_data(pins), .o_data(dev_d),
        .o_data_oe_n(dev_oe_n));

    // No pull on the wire: a released line shows the inverse of its past
    always @* begin
        if (!host_oe_n) begin
            pins = host_d;
        end else if (!dev_oe_n) begin
            pins = dev_d;
        end else begin
            pins = ~last;
        end
    end
    always @(posedge I_REF_CLK) begin
        if (!host_oe_n || !dev_oe_n) last <= pins;
    end

    // Pin watch at the falling edge, clear of the launching edge
    assign strb = {off_n, upd_n, wr_n};
    always @(negedge I_REF_CLK) begin
        if (!wr_n || !upd_n || !re_n) `CHK("select", 1'b0, sel_n)
        `CHK("drive in readback", 1'b0, !re_n && !host_oe_n)
        for (int k = 0; k < 3; k++) begin
            if (!strb[k]) begin
                lowc[k]++;
            end else if (lowc[k] != 0) begin
                `CHK("strobe width", 1'b1, lowc[k] * 8 >= 15)
                lowc[k] = 0;
            end
        end
    end

    // Closing report, reached from the end or from a spent wait
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge I_REF_CLK);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_REF_CLK);
        I_WR <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge I_REF_CLK);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_REF_CLK);
        I_RD <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // One command, then a bounded poll for done or refused
    task automatic cmd(input logic [2:0] op, input logic [4:0] a,
                       input logic [6:0] d, input logic refused);
        logic [31:0] st;
        int n;
        wr(`XP_REG_ROW_ADDR, {27'h0, a});
        wr(`XP_REG_ROW_DATA, {25'h0, d});
        wr(`XP_REG_CMD, {29'h0, op});
        n = 0;
        st = 32'h0;
        while (st[2:1] === 2'b00 && n < 60) begin
            rd(`XP_REG_STATUS, st);
            n++;
        end
        if (st[2:1] === 2'b00) begin
            fails++;
            test_done();
        end
        `CHK("refused flag", refused, st[`XP_ST_REFUSED])
        wr(`XP_REG_STATUS, 32'h6);
    endtask : cmd

    task automatic rows(input logic [6:0] lo, input logic [6:0] top);
        for (int i = 0; i < 16; i++) `CHK("rank two", lo, sw.rank2[i])
        `CHK("rank two row 16", top, sw.rank2[16])
    endtask : rows

    // Programming example, then readback of the top row
    task automatic t_example();
        logic [31:0] d;
        cmd(xp_pkg::OP_OFF, 5'h00, 7'h00, 1'b0);
        `CHK("off enable", 1'b0, sw.rank2[0][6])
        cmd(xp_pkg::OP_WRITE, 5'h11, 7'h47, 1'b0);
        cmd(xp_pkg::OP_WRITE, 5'h10, 7'h60, 1'b0);
        `CHK("held row", 7'h60, sw.rank1[16])
        cmd(xp_pkg::OP_UPDATE, 5'h00, 7'h00, 1'b0);
        rows(7'h47, 7'h60);
        cmd(xp_pkg::OP_READ, 5'h10, 7'h00, 1'b0);
        rd(`XP_REG_READBACK, d);
        `CHK("readback 16", 32'h60, d)
        $display("test example done");
    endtask : t_example

    // Off clears only rank-two enables; update restores from rank one
    task automatic t_off();
        logic [31:0] d;
        cmd(xp_pkg::OP_OFF, 5'h00, 7'h00, 1'b0);
        rows(7'h07, 7'h20);
        cmd(xp_pkg::OP_READ, 5'h03, 7'h00, 1'b0);
        rd(`XP_REG_READBACK, d);
        `CHK("readback 3", 32'h07, d)
        cmd(xp_pkg::OP_UPDATE, 5'h00, 7'h00, 1'b0);
        rows(7'h47, 7'h60);
        $display("test off done");
    endtask : t_off

    // Plain write waits for update; transparent write goes straight on
    task automatic t_single();
        cmd(xp_pkg::OP_WRITE, 5'h05, 7'h41, 1'b0);
        `CHK("rank one row 5", 7'h41, sw.rank1[5])
        `CHK("rank two row 5", 7'h47, sw.rank2[5])
        wr(`XP_REG_MODE, 32'h1);
        cmd(xp_pkg::OP_WRITE, 5'h06, 7'h46, 1'b0);
        `CHK("rank one row 6", 7'h46, sw.rank1[6])
        cmd(xp_pkg::OP_TWRITE, 5'h02, 7'h45, 1'b0);
        `CHK("rank two row 2", 7'h45, sw.rank2[2])
        `CHK("rank two row 5", 7'h41, sw.rank2[5])
        cmd(xp_pkg::OP_UPDATE, 5'h00, 7'h00, 1'b0);
        `CHK("rank two row 16", 7'h60, sw.rank2[16])
        wr(`XP_REG_MODE, 32'h0);
        $display("test single done");
    endtask : t_single

    // Illegal codes and out-of-range rows start nothing
    task automatic t_refuse();
        logic [31:0] d;
        cmd(3'h0, 5'h00, 7'h40, 1'b1);
        cmd(3'h6, 5'h00, 7'h40, 1'b1);
        cmd(3'h7, 5'h00, 7'h40, 1'b1);
        cmd(xp_pkg::OP_WRITE, 5'h12, 7'h40, 1'b1);
        cmd(xp_pkg::OP_WRITE, 5'h00, 7'h61, 1'b1);
        cmd(xp_pkg::OP_READ, 5'h11, 7'h00, 1'b1);
        `CHK("rank one row 0", 7'h47, sw.rank1[0])
        rd(8'h18, d);
        `CHK("unmapped read", 32'h0, d)
        $display("test refuse done");
    endtask : t_refuse

    initial begin
        repeat (3) @(posedge I_REF_CLK);
        I_NRST <= 1'b1;
        repeat (4) @(posedge I_REF_CLK);
        t_example();
        t_off();
        t_single();
        t_refuse();
        test_done();
    end
endmodule : xp_host_tb
`default_nettype wire
